// ### dsb_block_sync.sv
// Purpose: block sync engine with pull-in and forward protection
// Assumes: bit_en and hit come from logic on ref_clk
// Notes:   once pull-in starts, a hit counts only when it lands on the block boundary
`include "dsb_params.svh"
module dsb_block_sync
  import dsb_pkg::*;
#(
  parameter int BLK_BITS = `DSB_BLK_BITS,
  parameter int PW       = 9
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // timing carrier
  dsb_bs_if.engine bs
);
  if (BLK_BITS < 2 || BLK_BITS > (1 << PW)) $error("dsb_block_sync: BLK_BITS does not fit PW");

  localparam logic [PW-1:0] LAST = PW'(BLK_BITS - 1);

  typedef struct packed {
    dsb_bs_e       st;
    logic [PW-1:0] ph;
    dsb_prot_t     cnt;
    dsb_prot_t     miss;
  } dsb_bs_s;

  dsb_bs_s cur;
  dsb_bs_s next_cur;
  logic    wrap;

  assign wrap      = bs.bit_en && (cur.ph == LAST);
  assign bs.phase  = cur.ph;
  assign bs.locked = (cur.st == DSB_BS_LOCK);
  assign bs.tick   = wrap && (cur.st == DSB_BS_LOCK);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    if (bs.bit_en) begin
      next_cur.ph = wrap ? '0 : cur.ph + 1'b1;
    end
    if (bs.rst_req) begin
      next_cur.st   = DSB_BS_UNSYNC;
      next_cur.cnt  = '0;
      next_cur.miss = '0;
    end else begin
      case (cur.st)
        DSB_BS_UNSYNC: begin
          if (bs.hit && bs.bit_en) begin                 // pull-in starts
            next_cur.ph  = '0;
            next_cur.cnt = 4'h1;
            next_cur.st  = (bs.back_n <= 4'h1) ? DSB_BS_LOCK : DSB_BS_PULL;
          end
        end
        DSB_BS_PULL: begin
          if (wrap) begin
            if (bs.hit) begin
              next_cur.cnt = cur.cnt + 1'b1;
              if (cur.cnt + 1'b1 >= bs.back_n) begin
                next_cur.st = DSB_BS_LOCK;               // lock after back count
              end
            end else begin
              next_cur.st = DSB_BS_UNSYNC;
            end
          end
        end
        default: begin
          if (wrap) begin
            if (bs.hit) begin
              next_cur.miss = '0;
            end else if (cur.miss + 1'b1 >= bs.fwd_n) begin
              next_cur.st   = DSB_BS_UNSYNC;
              next_cur.miss = '0;
            end else begin
              next_cur.miss = cur.miss + 1'b1;
            end
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cur <= '{st: DSB_BS_UNSYNC, ph: '0, cnt: '0, miss: '0};
    end else begin
      cur <= next_cur;
    end
  end
endmodule

// ### dsb_bs_if.sv
// Purpose: carrier between frame logic and the block sync engine
// Assumes: one clock domain
// Notes:   ctrl side drives reset and counts, engine side reports timing
interface dsb_bs_if #(parameter int PW = 9);
  logic            bit_en;
  logic            hit;
  logic            rst_req;
  logic [3:0]      back_n;
  logic [3:0]      fwd_n;
  logic [PW-1:0]   phase;
  logic            tick;
  logic            locked;
  modport ctrl   (output bit_en, hit, rst_req, back_n, fwd_n, input phase, tick, locked);
  modport engine (input bit_en, hit, rst_req, back_n, fwd_n, output phase, tick, locked);
endinterface

// ### dsb_dual_station_sync.sv
// Purpose: dual-station block and frame sync with packet output tagging
// Assumes: bit_en, sync_hit and packet inputs come from ref_clk logic
// Notes:   frame timing follows a main phase counter, not block sync
`include "dsb_params.svh"
module dsb_dual_station_sync
  import dsb_pkg::*;
#(
  parameter int BLK_BITS = `DSB_BLK_BITS,
  parameter int FRM_BLKS = `DSB_FRM_BLKS,
  parameter int DW       = 8
)(
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  // register port
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata,
  // demodulator side
  input  wire logic          bit_en,
  input  wire logic          sync_hit,
  // horizontal and vertical correction results
  input  wire logic          hc_valid,
  input  wire logic          hc_ok,
  input  wire logic [DW-1:0] hc_data,
  input  wire logic          vc_valid,
  input  wire logic          vc_ok,
  input  wire logic [DW-1:0] vc_data,
  // packet output
  output logic               pkt_valid,
  output logic [7:0]         pkt_status,
  output logic [DW-1:0]      pkt_data,
  output logic               frame_start
);
  localparam int PW = 9;
  if (BLK_BITS < 2 || BLK_BITS > (1 << PW) || FRM_BLKS < 2 || FRM_BLKS > (1 << PW) || DW < 1)
    $error("dsb_dual_station_sync: geometry out of range");

  localparam logic [PW-1:0] BLAST = PW'(BLK_BITS - 1);
  localparam logic [PW-1:0] FLAST = PW'(FRM_BLKS - 1);

  typedef struct packed {
    logic          bsrst;
    logic          submode;
    dsb_prot_t     ffwd;
    dsb_prot_t     fback;
    dsb_prot_t     bback;
    dsb_prot_t     bfwd;
    logic [31:0]   rdata;
    logic [PW-1:0] mphase;
    logic [PW-1:0] fcnt;
    logic          fsync;
    dsb_prot_t     mm;
    dsb_prot_t     fb;
    logic [7:0]    bad;
    logic [7:0]    bad_last;
    logic          o_valid;
    logic [7:0]    o_status;
    logic [DW-1:0] o_data;
    logic          o_fstart;
  } dsb_top_s;

  dsb_top_s cur;
  dsb_top_s next_cur;
  logic     mwrap;
  logic     aligned;
  logic     foreign;

  dsb_bs_if #(.PW(PW)) bs ();

  assign bs.bit_en  = bit_en;
  assign bs.hit     = sync_hit;
  assign bs.rst_req = cur.bsrst;                       // block engine, frame protection, bad tally and hc output all see it
  assign bs.back_n  = cur.bback;
  assign bs.fwd_n   = cur.bfwd;

  dsb_block_sync #(.BLK_BITS(BLK_BITS), .PW(PW)) dsb_block_sync_i (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .bs      (bs)
  );

  // main-station block boundary and block timing comparison
  assign mwrap   = bit_en && (cur.mphase == BLAST);
  assign aligned = (bs.phase == cur.mphase);
  // sub-station data: locked on timing foreign to the main station
  assign foreign = bs.locked && !aligned;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur          = cur;
    next_cur.o_valid  = 1'b0;
    next_cur.o_fstart = 1'b0;

    // register writes
    if (reg_wr) begin
      if (reg_addr == `DSB_ADDR_CTRL) begin
        next_cur.bsrst   = reg_wdata[`DSB_CTRL_BSRST];
        next_cur.submode = reg_wdata[`DSB_CTRL_SUBMODE];
      end else if (reg_addr == `DSB_ADDR_PROT) begin
        next_cur.ffwd  = reg_wdata[`DSB_PROT_FFWD_LSB +: 4];
        next_cur.fback = reg_wdata[`DSB_PROT_FBACK_LSB +: 4];
        next_cur.bback = reg_wdata[`DSB_PROT_BBACK_LSB +: 4];
        next_cur.bfwd  = reg_wdata[`DSB_PROT_BFWD_LSB +: 4];
      end
    end

    // register reads, data valid the cycle after the strobe
    next_cur.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == `DSB_ADDR_CTRL) begin
        next_cur.rdata[`DSB_CTRL_BSRST]   = cur.bsrst;
        next_cur.rdata[`DSB_CTRL_SUBMODE] = cur.submode;
      end else if (reg_addr == `DSB_ADDR_PROT) begin
        next_cur.rdata[`DSB_PROT_FFWD_LSB +: 4]  = cur.ffwd;
        next_cur.rdata[`DSB_PROT_FBACK_LSB +: 4] = cur.fback;
        next_cur.rdata[`DSB_PROT_BBACK_LSB +: 4] = cur.bback;
        next_cur.rdata[`DSB_PROT_BFWD_LSB +: 4]  = cur.bfwd;
      end else if (reg_addr == `DSB_ADDR_STATUS) begin
        next_cur.rdata[`DSB_STAT_BLOCK]        = bs.locked;
        next_cur.rdata[`DSB_STAT_FRAME]        = cur.fsync;
        next_cur.rdata[`DSB_STAT_SUB]          = foreign;
        next_cur.rdata[`DSB_STAT_BAD_LSB +: 8] = cur.bad_last;
      end
    end

    // main-station block and frame counters run on their own timing
    if (bit_en) begin
      next_cur.mphase = mwrap ? '0 : cur.mphase + 1'b1;
    end
    if (mwrap) begin
      next_cur.fcnt = (cur.fcnt == FLAST) ? '0 : cur.fcnt + 1'b1;
      if (cur.fcnt == FLAST) begin
        next_cur.o_fstart = 1'b1;
        next_cur.bad_last = cur.bad;                  // per-frame tally
        next_cur.bad      = '0;
      end
    end

    // frame protection: ticks in sub mode or block reset never count while frame sync holds
    if (cur.fsync) begin
      if (bs.tick && !cur.submode && !cur.bsrst) begin
        if (aligned) begin
          next_cur.mm = '0;
        end else if (cur.mm + 1'b1 >= cur.ffwd) begin
          next_cur.fsync = 1'b0;                      // forward count spent
          next_cur.mm    = '0;
          next_cur.fb    = '0;
        end else begin
          next_cur.mm = cur.mm + 1'b1;
        end
      end
    end else if (bs.tick) begin
      // adopt the new block timing; the block tick is the phase zero
      next_cur.mphase = '0;
      if (aligned) begin
        next_cur.fb = cur.fb + 1'b1;
        if (cur.fb + 1'b1 >= cur.fback) begin
          next_cur.fsync = 1'b1;                      // back count reached
          next_cur.fcnt  = '0;
          next_cur.fb    = '0;
        end
      end else begin
        next_cur.fb = '0;
      end
    end

    // bad packets that the excursion did not cause
    if (hc_valid && !hc_ok && !foreign && !cur.submode && !cur.bsrst && cur.bad != 8'hFF) begin
      next_cur.bad = cur.bad + 1'b1;
    end

    // packet output: horizontal result first, real time
    if (hc_valid && bs.locked && !cur.bsrst) begin
      next_cur.o_valid                   = 1'b1;
      next_cur.o_data                    = hc_data;
      next_cur.o_status                  = '0;
      next_cur.o_status[`DSB_PKT_VC_BIT] = 1'b0;
      next_cur.o_status[`DSB_PKT_SUB_BIT] = foreign;  // sub-station data
      next_cur.o_status[`DSB_PKT_OK_BIT] = hc_ok;
    end else if (!hc_valid && vc_valid && vc_ok && cur.fsync && cur.bad_last == 8'h00) begin
      next_cur.o_valid                   = 1'b1;
      next_cur.o_data                    = vc_data;
      next_cur.o_status                  = '0;
      next_cur.o_status[`DSB_PKT_VC_BIT] = 1'b1;      // main station decoded
      next_cur.o_status[`DSB_PKT_OK_BIT] = 1'b1;
    end
  end

  // state register; hc wins a collision, the vertical packet is lost
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cur          <= '0;
      cur.ffwd     <= `DSB_FFWD_DEF;
      cur.fback    <= `DSB_FBACK_DEF;
      cur.bback    <= `DSB_BBACK_DEF;
      cur.bfwd     <= `DSB_BFWD_DEF;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from the state register
  assign reg_rdata   = cur.rdata;
  assign pkt_valid   = cur.o_valid;
  assign pkt_status  = cur.o_status;
  assign pkt_data    = cur.o_data;
  assign frame_start = cur.o_fstart;
endmodule

// ### dsb_host_model.sv
// Purpose: host processor driving the register port
// Assumes: strobes launched right after a rising edge
// Notes:   idle data lines carry the inverse of the last word
`include "dsb_params.svh"
module dsb_host_model
  import dsb_pkg::*;
(
  // clock
  input  wire logic        ref_clk,
  // register port
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // one-cycle write
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // one-cycle read, data taken in the slot after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask
  // tighter frame forward and block back protection for short excursions
  task automatic setup();
    wr_reg(`DSB_ADDR_PROT, 32'h0000_3223);
  endtask
  // block reset and sub mode, set around each retune
  task automatic ctl(input logic rst, input logic sub);
    wr_reg(`DSB_ADDR_CTRL, {24'h0, sub, 6'h0, rst});
  endtask
endmodule

// ### dsb_params.svh
// Purpose: named constants of the dual-station block/frame sync block
// Assumes: included by its bare name by the package and the modules
// Notes:   register offsets are byte addresses of 32-bit words
`ifndef DSB_PARAMS_SVH
`define DSB_PARAMS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define DSB_ADDR_CTRL       8'h00
`define DSB_ADDR_PROT       8'h04
`define DSB_ADDR_STATUS     8'h08

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DSB_CTRL_BSRST      0
`define DSB_CTRL_SUBMODE    7
`define DSB_PROT_FFWD_LSB   0
`define DSB_PROT_FBACK_LSB  4
`define DSB_PROT_BBACK_LSB  8
`define DSB_PROT_BFWD_LSB   12
`define DSB_STAT_BLOCK      0
`define DSB_STAT_FRAME      1
`define DSB_STAT_SUB        2
`define DSB_STAT_BAD_LSB    8
`define DSB_PKT_VC_BIT      7
`define DSB_PKT_SUB_BIT     6
`define DSB_PKT_OK_BIT      0

// ----------------------------------------------------------------
// reset values and geometry
// ----------------------------------------------------------------
`define DSB_FFWD_DEF        4'h7
`define DSB_FBACK_DEF       4'h2
`define DSB_BBACK_DEF       4'h1
`define DSB_BFWD_DEF        4'h3
`define DSB_BLK_BITS        288
`define DSB_FRM_BLKS        272
`endif

// ### dsb_pkg.sv
// Purpose: types shared by the dual-station sync modules
// Assumes: dsb_params.svh supplies the constants
// Notes:   block sync states are gray along unsync, pull-in, lock
`include "dsb_params.svh"
package dsb_pkg;
  typedef enum logic [1:0] {
    DSB_BS_UNSYNC = 2'b00,
    DSB_BS_PULL   = 2'b01,
    DSB_BS_LOCK   = 2'b11
  } dsb_bs_e;
  typedef logic [3:0] dsb_prot_t;
endpackage

// ### dsb_sync_monitor.sv
// Purpose: port-level checks of the dual-station sync block
// Assumes: one ref_clk domain, rstn active low
// Notes:   shadow_rst follows the block reset bit seen on bus writes
`include "dsb_params.svh"
module dsb_sync_monitor
  import dsb_pkg::*;
#(
  parameter int BLK_BITS = `DSB_BLK_BITS,
  parameter int FRM_BLKS = `DSB_FRM_BLKS,
  parameter int DW       = 8
)(
  // clock and reset
  input wire logic          ref_clk,
  input wire logic          rstn,
  // register port
  input wire logic [7:0]    reg_addr,
  input wire logic [31:0]   reg_wdata,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [31:0]   reg_rdata,
  // correction results
  input wire logic          hc_valid,
  input wire logic          hc_ok,
  input wire logic [DW-1:0] hc_data,
  input wire logic          vc_valid,
  input wire logic          vc_ok,
  input wire logic [DW-1:0] vc_data,
  // packet output
  input wire logic          pkt_valid,
  input wire logic [7:0]    pkt_status,
  input wire logic [DW-1:0] pkt_data,
  input wire logic          frame_start
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic shadow_rst;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // shadow of the block reset bit, the design applies it next cycle too
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) shadow_rst <= 1'b0;
    else if (reg_wr && reg_addr == `DSB_ADDR_CTRL) shadow_rst <= reg_wdata[`DSB_CTRL_BSRST];
  end
  a_rd_idle:
    assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("read data outside read slot");
  a_rd_hole:
    assert property (reg_rd && reg_addr >= 8'h0C |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
  a_pkt_cause:
    assert property (pkt_valid |-> $past(hc_valid) || $past(vc_valid)) else $error("packet without input");
  a_hc_flag:
    assert property (pkt_valid && $past(hc_valid) |-> !pkt_status[`DSB_PKT_VC_BIT]) else $error("hc packet flagged");
  a_hc_copy:
    assert property (pkt_valid && $past(hc_valid) |-> pkt_data == $past(hc_data) && pkt_status[0] == $past(hc_ok))
      else $error("hc packet content wrong");
  a_vc_copy:
    assert property (pkt_valid && !$past(hc_valid) |-> pkt_status[`DSB_PKT_VC_BIT] && pkt_data == $past(vc_data))
      else $error("vc packet content wrong");
  a_vc_clean:
    assert property ($past(vc_valid) && !$past(vc_ok) && !$past(hc_valid) |-> !pkt_valid) else $error("bad vc passed");
  a_rst_quiet:
    assert property ($past(hc_valid) && $past(shadow_rst) |-> !pkt_valid) else $error("hc passed in block reset");
  a_frame_pulse:
    assert property (frame_start |=> !frame_start [*2]) else $error("frame start too long");
  // main scenarios reached
  c_vc_out: cover property (pkt_valid && pkt_status[`DSB_PKT_VC_BIT]);
  c_hc_out: cover property (pkt_valid && !pkt_status[`DSB_PKT_VC_BIT]);
  c_sub_out: cover property (pkt_valid && pkt_status[`DSB_PKT_SUB_BIT]);
  c_frame:  cover property (frame_start);
endmodule

bind dsb_dual_station_sync dsb_sync_monitor #(.BLK_BITS(BLK_BITS), .FRM_BLKS(FRM_BLKS), .DW(DW)) dsb_sync_monitor_i (
  .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .hc_valid(hc_valid), .hc_ok(hc_ok), .hc_data(hc_data), .vc_valid(vc_valid),
  .vc_ok(vc_ok), .vc_data(vc_data), .pkt_valid(pkt_valid), .pkt_status(pkt_status), .pkt_data(pkt_data),
  .frame_start(frame_start));

// ### test_dual_station_block_sync.sv
// Purpose: self-checking bench of the dual-station sync block
// Assumes: shortened geometry, 8 bits per block, 4 blocks per frame
// Notes:   packets and checked reads are noted in queues by the driver
`include "dsb_params.svh"
`define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; $display("wrong value at %0t: %s", $time, m); end end
module test_dual_station_block_sync
  import dsb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // bench
  // ----------------------------------------------------------------
  localparam int DW = 8;
  localparam int BB = 8;
  // four blocks of BB bits, one bit every other 25 ns cycle
  localparam int FRAME_NS = 4 * BB * 2 * 25;
  logic ref_clk = 1'b0, rstn = 1'b0, bit_en = 1'b0, sync_hit = 1'b0, rd_q = 1'b0, seen_lost, exp_sub = 1'b0;
  logic hc_valid = 1'b0, hc_ok = 1'b0, vc_valid = 1'b0, vc_ok = 1'b0, pkt_valid, frame_start, reg_wr, reg_rd;
  logic [DW-1:0] hc_data = '0, vc_data = '0, pkt_data;
  logic [7:0] reg_addr, pkt_status;
  logic [31:0] reg_wdata, reg_rdata, rd_d, rq_e[$], rq_m[$];
  logic [DW+7:0] pq[$];
  time t_frame;
  int n_tests = 0, n_mismatch = 0, bit_cnt = 0, phase = 0;
  dsb_dual_station_sync #(.BLK_BITS(BB), .FRM_BLKS(4), .DW(DW)) dsb_dual_station_sync_i (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bit_en(bit_en), .sync_hit(sync_hit), .hc_valid(hc_valid), .hc_ok(hc_ok),
    .hc_data(hc_data), .vc_valid(vc_valid), .vc_ok(vc_ok), .vc_data(vc_data), .pkt_valid(pkt_valid),
    .pkt_status(pkt_status), .pkt_data(pkt_data), .frame_start(frame_start));
  dsb_host_model dsb_host_model_i (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // 40 MHz clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // demodulated bit stream, sync word at the tuned station's phase, junk off bit slots
  always @(posedge ref_clk) begin
    if (bit_en) bit_cnt = (bit_cnt + 1) % BB;
    bit_en   <= !bit_en && rstn;
    sync_hit <= bit_en ? 1'($urandom) : (bit_cnt == phase);
  end
  // watcher: oldest note against each result
  always @(posedge ref_clk) begin
    if (rd_q && rq_e.size() > 0) `CHK(reg_rdata & rq_m.pop_front(), rq_e.pop_front(), "register read")
    if (pkt_valid && pq.size() > 0) `CHK({pkt_status, pkt_data}, pq.pop_front(), "packet")
    else if (pkt_valid) `CHK(pkt_valid, 1'b0, "unexpected packet")
    rd_q <= reg_rd;
  end
  // one packet unit on the hc or vc path
  task automatic send(input logic vc, input logic ok, input logic out);
    logic [DW-1:0] d;
    d = DW'($urandom);
    @(posedge ref_clk);
    hc_valid <= !vc;
    vc_valid <= vc;
    hc_ok    <= ok;
    vc_ok    <= ok;
    hc_data  <= d;
    vc_data  <= d;
    if (out) pq.push_back({vc, exp_sub, 5'h00, ok, d});
    @(posedge ref_clk);
    hc_valid <= 1'b0;
    vc_valid <= 1'b0;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rq_e.push_back(e);
    rq_m.push_back(m);
    dsb_host_model_i.rd_reg(a, rd_d);
  endtask
  task automatic blocks(input int n);
    repeat (n * BB * 2) @(posedge ref_clk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(33));
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    chk_reg(`DSB_ADDR_PROT, 32'h0000_3127, 32'hFFFF_FFFF);
    chk_reg(`DSB_ADDR_CTRL, 32'h0, 32'hFFFF_FFFF);
    chk_reg(8'h0C, 32'h0, 32'hFFFF_FFFF);
    dsb_host_model_i.setup();
    chk_reg(`DSB_ADDR_PROT, 32'h0000_3223, 32'hFFFF_FFFF);
    $display("test defaults done");
    blocks(40);
    chk_reg(`DSB_ADDR_STATUS, 32'h3, 32'h7);
    // start at a frame edge so the bad unit falls inside one frame
    @(posedge frame_start);
    repeat (4) send(1'b0, 1'b1, 1'b1);
    send(1'b0, 1'b0, 1'b1);
    @(posedge frame_start);
    chk_reg(`DSB_ADDR_STATUS, 32'h0100, 32'hFF00);
    send(1'b1, 1'b1, 1'b0);
    @(posedge frame_start);
    t_frame = $time;
    send(1'b1, 1'b0, 1'b0);
    send(1'b1, 1'b1, 1'b1);
    $display("test main station done");
    dsb_host_model_i.ctl(1'b1, 1'b1);
    phase = 3;
    send(1'b0, 1'b1, 1'b0);
    dsb_host_model_i.ctl(1'b0, 1'b1);
    send(1'b0, 1'b1, 1'b0);
    blocks(3);
    chk_reg(`DSB_ADDR_STATUS, 32'h7, 32'h7);
    exp_sub = 1'b1;
    send(1'b0, 1'b1, 1'b1);
    exp_sub = 1'b0;
    dsb_host_model_i.ctl(1'b1, 1'b1);
    phase = 0;
    dsb_host_model_i.ctl(1'b0, 1'b0);
    blocks(4);
    chk_reg(`DSB_ADDR_STATUS, 32'h3, 32'h7);
    chk_reg(`DSB_ADDR_PROT, 32'h0000_3223, 32'hFFFF_FFFF);
    // frame edges must stay on the main station's grid across the excursion
    @(posedge frame_start);
    `CHK(($time - t_frame) % FRAME_NS, 0, "frame timing moved")
    $display("test excursion done");
    phase = 5;
    seen_lost = 1'b0;
    repeat (100) begin
      dsb_host_model_i.rd_reg(`DSB_ADDR_STATUS, rd_d);
      if (rd_d[1] === 1'b0) seen_lost = 1'b1;
    end
    `CHK(seen_lost, 1'b1, "frame sync never dropped")
    blocks(20);
    chk_reg(`DSB_ADDR_STATUS, 32'h3, 32'h7);
    blocks(2);
    `CHK(pq.size(), 0, "missing packets")
    $display("test persistent shift done");
    wrap_up();
  end
  // watchdog, well beyond the few thousand cycles the tests need
  initial begin
    #500us;
    n_mismatch++;
    $display("wrong value at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
